// file: tsi_params.svh
`ifndef TSI_PARAMS_SVH
`define TSI_PARAMS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
`define TSI_CLK_NS 10
`define TSI_SPIKE_NS 50
`define TSI_FILT_CYC ((`TSI_SPIKE_NS) / (`TSI_CLK_NS))
`define TSI_MAX_KBPS 400

// ----------------------------------------
// Framing
// ----------------------------------------
`define TSI_BYTE_LAST 4'h7
`define TSI_ACK_SLOT 4'h8
`define TSI_BIT_ZERO 4'h0

// ----------------------------------------
// Addresses and reset values
// ----------------------------------------
// Arbitrary bus address, not tied to any product
`define TSI_OWN_ADDR 7'h2C
`define TSI_PTR_RESET 8'h00
`define TSI_PTR_LAST 8'h44
`define TSI_STATUS_REG 8'h00
`define TSI_STATUS_RESET 3'h0
`define TSI_FIFO_DEPTH 32

`endif

// file: tsi_pkg.sv
package tsi_pkg;

	// ----------------------------------------
	// Byte-level protocol states
	// ----------------------------------------
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ADDR,
		ST_PTR,
		ST_WDATA,
		ST_RDATA,
		ST_IGNORE
	} tsi_state_t;

	// ----------------------------------------
	// Register write carried to the core
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} tsi_wr_t;

endpackage : tsi_pkg

// file: tsi_fifo.sv
`timescale 1ns/1ns

module tsi_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic out_valid_r;
	logic [WIDTH-1:0] out_data_r;

	// Output word sits in a register so the top drives it from a flop
	wire full = (count_r == (AW+1)'(DEPTH));
	wire empty = (count_r == '0);
	wire push = in_valid && !full;
	wire load = !empty && (!out_valid_r || out_ready);

	assign in_ready = !full;
	assign out_valid = out_valid_r;
	assign out_data = out_data_r;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr_r] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
			out_valid_r <= 1'b0;
			out_data_r <= '0;
		end else begin
			if (push) begin
				wr_ptr_r <= wr_ptr_r + AW'(1);
			end
			if (load) begin
				rd_ptr_r <= rd_ptr_r + AW'(1);
				out_data_r <= mem[rd_ptr_r];
				out_valid_r <= 1'b1;
			end else if (out_ready) begin
				out_valid_r <= 1'b0;
			end
			case ({push, load})
				2'b10: count_r <= count_r + (AW+1)'(1);
				2'b01: count_r <= count_r - (AW+1)'(1);
				default: count_r <= count_r;
			endcase
		end
	end

endmodule : tsi_fifo

// file: tsi_slave_port.sv
`timescale 1ns/1ns
`include "tsi_params.svh"

module tsi_slave_port #(
	parameter logic [6:0] OWN_ADDR = `TSI_OWN_ADDR,
	parameter int FILT_CYC = `TSI_FILT_CYC,
	parameter int FIFO_DEPTH = `TSI_FIFO_DEPTH
) (
	// System
	input wire logic CLOCK,
	input wire logic RESET,
	// Two-wire link
	input wire logic SCL_LINK,
	input wire logic SDA_IN,
	output logic SDA_OUT,
	output logic SDA_OE,
	// Shared alert or third electrode pin
	input wire logic SHARED_PIN_IN,
	output logic SHARED_PIN_OUT,
	output logic SHARED_PIN_OE,
	// Sensing core
	input wire logic ALERT_MODE,
	input wire logic [2:0] TOUCH_STATUS,
	output logic THIRD_ELECTRODE_LEVEL,
	// Register access
	output logic [7:0] REG_PTR,
	input wire logic [7:0] RD_DATA,
	output tsi_pkg::tsi_wr_t WR_WORD,
	output logic WR_VALID,
	input wire logic WR_READY,
	// Status
	output logic BUS_BUSY
);
	localparam int CW = $clog2(FILT_CYC + 1);

	// ----------------------------------------
	// Link clock domain
	// ----------------------------------------
	// The master clock stands still outside frames, so these flops hold
	// their power-up value instead of taking a reset from the other domain.
	logic cap_bit_r = 1'b1;
	logic cap_tgl_r = 1'b0;

	always_ff @(posedge SCL_LINK) begin
		cap_bit_r <= SDA_IN;
		cap_tgl_r <= ~cap_tgl_r;
	end

	// ----------------------------------------
	// Bit event crossing
	// ----------------------------------------
	logic tgl_s1_r;
	logic tgl_s2_r;
	logic tgl_s3_r;

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			tgl_s1_r <= 1'b0;
			tgl_s2_r <= 1'b0;
			tgl_s3_r <= 1'b0;
		end else begin
			tgl_s1_r <= cap_tgl_r;
			tgl_s2_r <= tgl_s1_r;
			tgl_s3_r <= tgl_s2_r;
		end
	end

	// Captured bit stays put until the next rising clock, microseconds away
	wire bit_ev = tgl_s2_r ^ tgl_s3_r;
	wire bit_val = cap_bit_r;

	// ----------------------------------------
	// Line synchronisers and glitch filters
	// ----------------------------------------
	wire [1:0] line_raw = {SCL_LINK, SDA_IN};
	logic [1:0] line_filt;

	for (genvar i = 0; i < 2; i++) begin : g_line
		logic s1_r;
		logic s2_r;
		logic filt_r;
		logic [CW-1:0] cnt_r;
		wire differs = (s2_r != filt_r);
		wire settled = (cnt_r == CW'(FILT_CYC - 1));

		always_ff @(posedge CLOCK) begin
			if (RESET) begin
				s1_r <= 1'b1;
				s2_r <= 1'b1;
				filt_r <= 1'b1;
				cnt_r <= '0;
			end else begin
				s1_r <= line_raw[i];
				s2_r <= s1_r;
				if (differs && settled) begin
					filt_r <= s2_r;
					cnt_r <= '0;
				end else if (differs) begin
					cnt_r <= cnt_r + CW'(1);
				end else begin
					cnt_r <= '0;
				end
			end
		end
		assign line_filt[i] = filt_r;
	end

	// ----------------------------------------
	// Condition detection
	// ----------------------------------------
	logic scl_q_r;
	logic sda_q_r;

	wire scl_f = line_filt[1];
	wire sda_f = line_filt[0];
	wire start_ev = scl_f && scl_q_r && sda_q_r && !sda_f;
	wire stop_ev = scl_f && scl_q_r && !sda_q_r && sda_f;
	wire scl_fall = scl_q_r && !scl_f;

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
		end else begin
			scl_q_r <= scl_f;
			sda_q_r <= sda_f;
		end
	end

	// ----------------------------------------
	// Byte engine state
	// ----------------------------------------
	tsi_pkg::tsi_state_t state_r;
	tsi_pkg::tsi_state_t state_nxt;
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic [7:0] shift_r;
	logic [7:0] shift_nxt;
	logic [7:0] tx_r;
	logic [7:0] tx_nxt;
	logic [7:0] ptr_r;
	logic [7:0] ptr_nxt;
	logic ack_r;
	logic ack_nxt;
	logic oe_r;
	logic oe_nxt;
	logic push_r;
	logic push_nxt;
	tsi_pkg::tsi_wr_t word_r;
	tsi_pkg::tsi_wr_t word_nxt;
	logic clr_alert;
	logic fifo_in_ready;

	wire [7:0] byte_in = {shift_r[6:0], bit_val};
	wire byte_done = bit_ev && (cnt_r == `TSI_BYTE_LAST);
	wire ack_bit = bit_ev && (cnt_r == `TSI_ACK_SLOT);
	wire addr_hit = (byte_in[7:1] == OWN_ADDR);
	wire in_frame = (state_r != tsi_pkg::ST_IDLE) && (state_r != tsi_pkg::ST_IGNORE);
	wire ptr_wrap = (ptr_r == `TSI_PTR_LAST);
	wire [7:0] ptr_inc = ptr_wrap ? `TSI_PTR_RESET : ptr_r + 8'h01;

	// ----------------------------------------
	// Byte engine
	// ----------------------------------------
	// The engine only ever answers; nothing here can start a frame.
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		shift_nxt = shift_r;
		tx_nxt = tx_r;
		ptr_nxt = ptr_r;
		ack_nxt = ack_r;
		oe_nxt = oe_r;
		push_nxt = 1'b0;
		word_nxt = word_r;
		clr_alert = 1'b0;
		if (start_ev) begin
			state_nxt = tsi_pkg::ST_ADDR;
			cnt_nxt = `TSI_BIT_ZERO;
			ack_nxt = 1'b0;
			oe_nxt = 1'b0;
		end else if (stop_ev) begin
			state_nxt = tsi_pkg::ST_IDLE;
			cnt_nxt = `TSI_BIT_ZERO;
			ack_nxt = 1'b0;
			oe_nxt = 1'b0;
		end else begin
			if (in_frame && ack_bit) begin
				cnt_nxt = `TSI_BIT_ZERO;
				ack_nxt = 1'b0;
				if (state_r == tsi_pkg::ST_RDATA && bit_val) begin
					state_nxt = tsi_pkg::ST_IGNORE;
				end
			end else if (in_frame && bit_ev) begin
				shift_nxt = byte_in;
				cnt_nxt = cnt_r + 4'h1;
			end
			if (in_frame && byte_done) begin
				if (state_r == tsi_pkg::ST_ADDR) begin
					if (addr_hit) begin
						ack_nxt = 1'b1;
						state_nxt = byte_in[0] ? tsi_pkg::ST_RDATA : tsi_pkg::ST_PTR;
					end else begin
						ack_nxt = 1'b0;
						state_nxt = tsi_pkg::ST_IGNORE;
					end
				end else if (state_r == tsi_pkg::ST_PTR) begin
					ptr_nxt = byte_in;
					ack_nxt = 1'b1;
					state_nxt = tsi_pkg::ST_WDATA;
				end else if (state_r == tsi_pkg::ST_WDATA) begin
					if (fifo_in_ready) begin
						push_nxt = 1'b1;
						word_nxt = '{addr: ptr_r, data: byte_in};
						ptr_nxt = ptr_inc;
						ack_nxt = 1'b1;
					end else begin
						// No room: refuse the byte rather than lose it
						ack_nxt = 1'b0;
						state_nxt = tsi_pkg::ST_IGNORE;
					end
				end else if (state_r == tsi_pkg::ST_RDATA) begin
					ptr_nxt = ptr_inc;
					ack_nxt = 1'b0;
					clr_alert = (ptr_r == `TSI_STATUS_REG);
				end
			end
			// Line only moves after the clock has gone low
			if (scl_fall) begin
				if (cnt_r == `TSI_ACK_SLOT) begin
					oe_nxt = ack_r;
				end else if (state_r == tsi_pkg::ST_RDATA) begin
					if (cnt_r == `TSI_BIT_ZERO) begin
						tx_nxt = RD_DATA;
						oe_nxt = ~RD_DATA[7];
					end else begin
						tx_nxt = {tx_r[6:0], 1'b1};
						oe_nxt = ~tx_r[6];
					end
				end else begin
					oe_nxt = 1'b0;
				end
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			state_r <= tsi_pkg::ST_IDLE;
			cnt_r <= `TSI_BIT_ZERO;
			shift_r <= 8'h00;
			tx_r <= 8'hFF;
			ptr_r <= `TSI_PTR_RESET;
			ack_r <= 1'b0;
			oe_r <= 1'b0;
			push_r <= 1'b0;
			word_r <= '0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			shift_r <= shift_nxt;
			tx_r <= tx_nxt;
			ptr_r <= ptr_nxt;
			ack_r <= ack_nxt;
			oe_r <= oe_nxt;
			push_r <= push_nxt;
			word_r <= word_nxt;
		end
	end

	// ----------------------------------------
	// Write buffer toward the register core
	// ----------------------------------------
	tsi_pkg::tsi_wr_t fifo_out;

	tsi_fifo #(
		.WIDTH($bits(tsi_pkg::tsi_wr_t)),
		.DEPTH(FIFO_DEPTH)
	) u_wr_fifo (
		.clk(CLOCK),
		.rst(RESET),
		.in_valid(push_r),
		.in_ready(fifo_in_ready),
		.in_data(word_r),
		.out_valid(WR_VALID),
		.out_ready(WR_READY),
		.out_data(fifo_out)
	);

	assign WR_WORD = fifo_out;

	// ----------------------------------------
	// Shared pin
	// ----------------------------------------
	logic mode_r;
	logic alert_r;
	logic alert_nxt;
	logic [2:0] status_q_r;
	logic pin_s1_r;
	logic pin_s2_r;
	logic third_r;

	// Set wins over clear; mode is read unregistered so a change with it is not lost
	wire status_changed = (TOUCH_STATUS != status_q_r);
	assign alert_nxt = ALERT_MODE && (status_changed || (alert_r && !clr_alert));

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			mode_r <= 1'b0;
			alert_r <= 1'b0;
			status_q_r <= `TSI_STATUS_RESET;
			pin_s1_r <= 1'b1;
			pin_s2_r <= 1'b1;
			third_r <= 1'b0;
		end else begin
			mode_r <= ALERT_MODE;
			alert_r <= alert_nxt;
			status_q_r <= TOUCH_STATUS;
			pin_s1_r <= SHARED_PIN_IN;
			pin_s2_r <= pin_s1_r;
			third_r <= !mode_r && pin_s2_r;
		end
	end

	// ----------------------------------------
	// Status and pin outputs
	// ----------------------------------------
	logic busy_r;
	logic low_r;

	always_ff @(posedge CLOCK) begin
		if (RESET) begin
			busy_r <= 1'b0;
			low_r <= 1'b0;
		end else begin
			busy_r <= (state_nxt != tsi_pkg::ST_IDLE);
			low_r <= 1'b0;
		end
	end

	// No clock output exists at all, so the master's timing is never held
	assign SDA_OUT = low_r;
	assign SDA_OE = oe_r;
	assign SHARED_PIN_OUT = low_r;
	assign SHARED_PIN_OE = alert_r;
	assign THIRD_ELECTRODE_LEVEL = third_r;
	assign REG_PTR = ptr_r;
	assign BUS_BUSY = busy_r;

endmodule : tsi_slave_port

// file: tsi_bus_master.sv
`timescale 1ns/1ns

module tsi_bus_master #(
	// Phase length in system clocks; 1.25 us per phase holds the bus at 400 kbit/s
	parameter int HP = 125
) (
	// Clock
	input wire logic clk,
	// Bus lines
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	// ----
	// Bus sequencing
	// ----
	initial begin
		scl = 1'h1;
		sda_low = 1'h0;
	end

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk);
	endtask : wait_n

	// Also a repeated start: data is released before the clock rises
	task automatic start();
		sda_low <= 1'h0;
		wait_n(HP / 2);
		scl <= 1'h1;
		wait_n(HP);
		sda_low <= 1'h1;
		wait_n(HP);
		scl <= 1'h0;
	endtask : start

	task automatic stop();
		wait_n(HP / 2);
		sda_low <= 1'h1;
		wait_n(HP / 2);
		scl <= 1'h1;
		wait_n(HP);
		sda_low <= 1'h0;
		wait_n(HP);
	endtask : stop

	// Data moves mid low phase, sampled at the end of the high phase
	task automatic bit_x(input logic b, output logic r);
		wait_n(HP / 2);
		sda_low <= ~b;
		wait_n(HP / 2);
		scl <= 1'h1;
		wait_n(HP);
		r = sda;
		scl <= 1'h0;
	endtask : bit_x

	// Byte MSB first, then the ninth clock; a high ack_tx releases the line
	task automatic xfer(input logic [7:0] tx, input logic ack_tx,
		output logic [7:0] rx, output logic ack_rx);
		for (int i = 7; i >= 0; i--) begin
			bit_x(tx[i], rx[i]);
		end
		bit_x(ack_tx, ack_rx);
	endtask : xfer
endmodule : tsi_bus_master

// file: tsi_slave_port_chk.sv
`timescale 1ns/1ns

module tsi_slave_port_chk (
	// System
	input logic CLOCK,
	input logic RESET,
	// Watched ports
	input logic SCL_LINK,
	input logic SDA_IN,
	input logic SDA_OUT,
	input logic SDA_OE,
	input logic SHARED_PIN_OUT,
	input logic SHARED_PIN_OE,
	input logic ALERT_MODE,
	input logic [2:0] TOUCH_STATUS,
	input logic [7:0] REG_PTR,
	input tsi_pkg::tsi_wr_t WR_WORD,
	input logic WR_VALID,
	input logic WR_READY,
	input logic BUS_BUSY
);
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RESET);

	a_data_pulls_low: assert property (!SDA_OUT)
		else $error("data pin driven high");
	a_pin_pulls_low: assert property (!SHARED_PIN_OUT)
		else $error("shared pin driven high");
	a_idle_released: assert property (!BUS_BUSY |-> !SDA_OE)
		else $error("data driven on idle bus");
	a_change_clock_low: assert property ($changed(SDA_OE) |-> !SCL_LINK)
		else $error("data changed with clock high");
	a_start_busy: assert property ($fell(SDA_IN) && SCL_LINK |-> ##[4:12] BUS_BUSY)
		else $error("start not detected");
	a_stop_frees: assert property ($rose(SDA_IN) && SCL_LINK |-> ##[4:12] !BUS_BUSY)
		else $error("stop not detected");
	a_alert_set: assert property (ALERT_MODE && TOUCH_STATUS != $past(TOUCH_STATUS)
		|-> ##[1:3] SHARED_PIN_OE)
		else $error("alert not raised");
	a_alert_mode_off: assert property (!ALERT_MODE && !$past(ALERT_MODE) |-> !SHARED_PIN_OE)
		else $error("alert driven in electrode mode");
	a_word_held: assert property (WR_VALID && !WR_READY |=> WR_VALID && $stable(WR_WORD))
		else $error("write word dropped");
	a_reset_values: assert property ($past(RESET)
		|-> !SDA_OE && !BUS_BUSY && !WR_VALID && REG_PTR == 8'h00)
		else $error("bad value after reset");
endmodule : tsi_slave_port_chk

bind tsi_slave_port tsi_slave_port_chk u_chk (.CLOCK(CLOCK), .RESET(RESET), .SCL_LINK(SCL_LINK),
	.SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SHARED_PIN_OUT(SHARED_PIN_OUT),
	.SHARED_PIN_OE(SHARED_PIN_OE), .ALERT_MODE(ALERT_MODE), .TOUCH_STATUS(TOUCH_STATUS),
	.REG_PTR(REG_PTR), .WR_WORD(WR_WORD), .WR_VALID(WR_VALID), .WR_READY(WR_READY),
	.BUS_BUSY(BUS_BUSY));

// file: tsi_slave_port_tb.sv
`timescale 1ns/1ns
`include "tsi_params.svh"

module tsi_slave_port_tb;
	// ----
	// Signals
	// ----
	logic clk, rst, alert_mode, pin_drv, wr_rdy, scl, sda_low;
	logic sda_out, sda_oe, pin_out, pin_oe, third, wr_valid, busy;
	logic [2:0] touch;
	logic [7:0] reg_ptr;
	logic [7:0] rd_data;
	tsi_pkg::tsi_wr_t wr_word;
	int error_cnt = 0;
	int check_count = 0;
	localparam logic [6:0] ADDR = `TSI_OWN_ADDR;
	// A shallow buffer keeps the fill run short at the full bit rate
	localparam int FILL_DEPTH = 8;
	// Open-drain wires with pull-ups
	wire sda_w = ~(sda_low | (sda_oe & ~sda_out));
	wire pin_w = pin_drv & ~(pin_oe & ~pin_out);
	// Core stand-in: each register reads as its address mixed with A0
	assign rd_data = reg_ptr ^ 8'hA0;

	initial begin
		clk = 1'h0;
		forever #5 clk = ~clk;
	end

	tsi_bus_master m (.clk(clk), .scl(scl), .sda_low(sda_low), .sda(sda_w));

	tsi_slave_port #(.FIFO_DEPTH(FILL_DEPTH)) dut (.CLOCK(clk), .RESET(rst), .SCL_LINK(scl),
		.SDA_IN(sda_w),
		.SDA_OUT(sda_out), .SDA_OE(sda_oe), .SHARED_PIN_IN(pin_w), .SHARED_PIN_OUT(pin_out),
		.SHARED_PIN_OE(pin_oe), .ALERT_MODE(alert_mode), .TOUCH_STATUS(touch),
		.THIRD_ELECTRODE_LEVEL(third), .REG_PTR(reg_ptr), .RD_DATA(rd_data),
		.WR_WORD(wr_word), .WR_VALID(wr_valid), .WR_READY(wr_rdy), .BUS_BUSY(busy));

	// ----
	// Helpers
	// ----
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk

	task automatic head(input logic [7:0] ptr);
		logic a;
		logic [7:0] r;
		m.start();
		m.xfer({ADDR, 1'h0}, 1'h1, r, a);
		chk("address ack", 16'h0000, a);
		m.xfer(ptr, 1'h1, r, a);
		chk("pointer ack", 16'h0000, a);
		chk("busy", 16'h0001, busy);
	endtask : head

	task automatic rd(input logic [7:0] ptr, input int n);
		logic a;
		logic [7:0] r;
		head(ptr);
		m.start();
		m.xfer({ADDR, 1'h1}, 1'h1, r, a);
		chk("read address ack", 16'h0000, a);
		for (int i = 0; i < n; i++) begin
			m.xfer(8'hFF, i == n - 1, r, a);
			chk("read byte", 8'(ptr + i) ^ 8'hA0, r);
		end
		m.stop();
		chk("pointer after read", 8'(ptr + n), reg_ptr);
	endtask : rd

	// ----
	// Scenarios
	// ----
	task automatic t_write();
		logic a;
		logic [7:0] r;
		head(8'h43);
		m.xfer(8'hA5, 1'h1, r, a);
		chk("data ack", 16'h0000, a);
		m.xfer(8'h5A, 1'h1, r, a);
		m.stop();
		chk("busy after stop", 16'h0000, busy);
		chk("first word", 16'h43A5, wr_word);
		chk("pointer wrap", 16'h0000, reg_ptr);
		wr_rdy <= 1'h1;
		@(posedge clk);
		wr_rdy <= 1'h0;
		repeat (5) @(posedge clk);
		chk("second word", 16'h445A, wr_word);
		wr_rdy <= 1'h1;
		@(posedge clk);
		wr_rdy <= 1'h0;
		repeat (5) @(posedge clk);
		chk("drained", 16'h0000, wr_valid);
	endtask : t_write

	task automatic t_pointer_then_read();
		head(8'h44);
		m.stop();
		chk("pointer only", 16'h0044, reg_ptr);
		rd(8'h02, 2);
	endtask : t_pointer_then_read

	task automatic t_foreign();
		logic a;
		logic [7:0] r;
		m.start();
		m.xfer({ADDR ^ 7'h01, 1'h0}, 1'h1, r, a);
		chk("foreign nack", 16'h0001, a);
		m.xfer(8'h00, 1'h1, r, a);
		chk("ignored byte", 16'h0001, a);
		m.stop();
		chk("no write", 16'h0000, wr_valid);
	endtask : t_foreign

	// Core stalls while the buffer fills, then drains it
	task automatic t_fill();
		int n;
		logic a;
		logic [7:0] r;
		n = 0;
		head(8'h10);
		for (int i = 0; i < 40; i++) begin
			m.xfer(8'(i), 1'h1, r, a);
			if (a) break;
			n++;
		end
		m.stop();
		chk("words taken", 16'(FILL_DEPTH + 1), 16'(n));
		chk("oldest word", 16'h1000, wr_word);
		n = 0;
		wr_rdy <= 1'h1;
		repeat (100) begin
			@(posedge clk);
			n += int'(wr_valid === 1'h1);
		end
		wr_rdy <= 1'h0;
		chk("words drained", 16'(FILL_DEPTH + 1), 16'(n));
	endtask : t_fill

	task automatic t_alert();
		alert_mode <= 1'h1;
		touch <= 3'h5;
		repeat (4) @(posedge clk);
		chk("alert raised", 16'h0001, pin_oe);
		chk("alert pin low", 16'h0000, pin_w);
		rd(8'h00, 1);
		chk("alert cleared", 16'h0000, pin_oe);
		alert_mode <= 1'h0;
		repeat (20) @(posedge clk);
		chk("third high", 16'h0001, third);
		pin_drv <= 1'h0;
		repeat (20) @(posedge clk);
		chk("third low", 16'h0000, third);
	endtask : t_alert

	task automatic tally_and_finish();
		$display("Errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		rst = 1'h1;
		alert_mode = 1'h0;
		touch = 3'h0;
		pin_drv = 1'h1;
		wr_rdy = 1'h0;
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		repeat (20) @(posedge clk);
		chk("pointer reset", 16'h0000, reg_ptr);
		chk("data released", 16'h0000, sda_oe);
		t_write();
		t_pointer_then_read();
		t_foreign();
		t_fill();
		t_alert();
		tally_and_finish();
	end

	// Whole run is about 70000 cycles at the full bit rate
	initial begin
		repeat (90000) @(posedge clk);
		error_cnt++;
		tally_and_finish();
	end
endmodule : tsi_slave_port_tb
